//--- hw/boot_strap_pkg.sv
// Purpose: Shared constants and types for the boot configuration loader.
// Assumes: Configuration bytes are eight bits wide.
// Notes: Field positions inside the bytes are held here only.
`default_nettype none

package boot_strap_pkg;

	// Byte widths and the lowest strapped bit of each partial byte.
	localparam int CFG_W                = 8;
	localparam int MODE_W               = 2;
	localparam int BYTE_TWO_STRAP_LSB   = 2;
	localparam int BYTE_THREE_STRAP_LSB = 1;

	// Values held before the first capture.
	localparam logic [CFG_W-1:0]  CFG_RESET  = 8'h00;
	localparam logic [MODE_W-1:0] MODE_RESET = 2'h0;
	localparam logic              SEL_RESET  = 1'h0;

	// Boot device field in byte one.
	localparam int             DEV_MSB     = 7;
	localparam int             DEV_LSB     = 4;
	localparam logic [3:0]     DEV_EXT_BUS = 4'h0;
	localparam logic [3:0]     DEV_NAND    = 4'h1;
	localparam logic [3:0]     DEV_SPI     = 4'h3;

	// Controller instance field in byte three for serial boot.
	localparam int             SPI_INST_MSB = 5;
	localparam int             SPI_INST_LSB = 4;
	localparam logic [1:0]     SPI_LEGACY   = 2'h0;
	localparam logic [1:0]     SPI_ONE      = 2'h1;
	localparam logic [1:0]     SPI_TWO      = 2'h2;

	// Interface option bits in byte two.
	localparam int EXT_UPPER_BIT  = 3;
	localparam int NAND_WIDE_BIT  = 4;
	localparam int NAND_ROUTE_BIT = 5;

	// Pad groups handed to the pad multiplexer, one enable each.
	localparam int PAD_GROUPS     = 8;
	localparam int PAD_LEGACY_SPI = 0;
	localparam int PAD_SPI_ONE    = 1;
	localparam int PAD_SPI_TWO    = 2;
	localparam int PAD_EXT_CTRL   = 3;
	localparam int PAD_EXT_LOWER  = 4;
	localparam int PAD_EXT_UPPER  = 5;
	localparam int PAD_NAND_CTRL  = 6;
	localparam int PAD_PATA_DATA  = 7;
	localparam logic [PAD_GROUPS-1:0] PAD_NONE = 8'h00;

	// Capture sequence states.
	typedef enum logic [1:0] {
		load_capture = 2'b00,
		load_hold    = 2'b01
	} load_state_t;

endpackage

`default_nettype wire

//--- hw/boot_cfg_if.sv
// Purpose: Carries the captured configuration to the pad steering logic and back.
// Assumes: Both ends run on the same clock.
// Notes: No clocking block; plain signals only.
`default_nettype none

interface boot_cfg_if;
	logic [boot_strap_pkg::CFG_W-1:0]      byte_one;
	logic [boot_strap_pkg::CFG_W-1:0]      byte_two;
	logic [boot_strap_pkg::CFG_W-1:0]      byte_three;
	logic                                  captured;
	logic                                  boot_active;
	logic [boot_strap_pkg::PAD_GROUPS-1:0] pad_group_enable;
	logic                                  slave_select_one_enable;
	logic                                  chip_select_zero_enable;
	logic                                  external_bus_multiplexed;
	logic                                  nand_wide;
	logic                                  nand_over_pata;

	modport loader (
		output byte_one, byte_two, byte_three, captured, boot_active,
		input  pad_group_enable, slave_select_one_enable, chip_select_zero_enable,
		input  external_bus_multiplexed, nand_wide, nand_over_pata
	);

	modport steer (
		input  byte_one, byte_two, byte_three, captured, boot_active,
		output pad_group_enable, slave_select_one_enable, chip_select_zero_enable,
		output external_bus_multiplexed, nand_wide, nand_over_pata
	);
endinterface

`default_nettype wire

//--- hw/boot_pad_steer.sv
// Purpose: Turns the captured boot configuration into pad group enables.
// Assumes: Configuration is stable once captured is high.
// Notes: Outputs are registered, one cycle behind their inputs.
`default_nettype none

module boot_pad_steer (
	input  wire logic clock,
	input  wire logic rst_b,
	boot_cfg_if.steer cfg
);

	logic [boot_strap_pkg::PAD_GROUPS-1:0] pads;
	logic [boot_strap_pkg::PAD_GROUPS-1:0] next_pads;
	logic                                  ss_one;
	logic                                  next_ss_one;
	logic                                  cs_zero;
	logic                                  next_cs_zero;
	logic                                  ext_mux;
	logic                                  next_ext_mux;
	logic                                  wide;
	logic                                  next_wide;
	logic                                  over_pata;
	logic                                  next_over_pata;
	logic [3:0]                            dev;
	logic [1:0]                            spi_inst;

	// Picks the pad groups of at most one boot interface while boot runs.
	always_comb
	begin
		dev            = cfg.byte_one[boot_strap_pkg::DEV_MSB:boot_strap_pkg::DEV_LSB];
		spi_inst       = cfg.byte_three[boot_strap_pkg::SPI_INST_MSB:boot_strap_pkg::SPI_INST_LSB];
		next_pads      = boot_strap_pkg::PAD_NONE;
		next_ss_one    = 1'b0;
		next_cs_zero   = 1'b0;
		next_ext_mux   = 1'b0;
		next_wide      = 1'b0;
		next_over_pata = 1'b0;
		if (cfg.boot_active && cfg.captured) // [RQ5]
		begin
			case (dev)
				boot_strap_pkg::DEV_SPI:
				begin
					next_ss_one = 1'b1; // [RQ6]
					case (spi_inst)
						boot_strap_pkg::SPI_LEGACY: next_pads[boot_strap_pkg::PAD_LEGACY_SPI] = 1'b1;
						boot_strap_pkg::SPI_ONE:    next_pads[boot_strap_pkg::PAD_SPI_ONE] = 1'b1;
						boot_strap_pkg::SPI_TWO:    next_pads[boot_strap_pkg::PAD_SPI_TWO] = 1'b1;
						default:                    next_ss_one = 1'b0;
					endcase
				end
				boot_strap_pkg::DEV_EXT_BUS:
				begin
					next_cs_zero = 1'b1; // [RQ7]
					next_pads[boot_strap_pkg::PAD_EXT_CTRL] = 1'b1;
					if (cfg.byte_two[boot_strap_pkg::EXT_UPPER_BIT])
						next_pads[boot_strap_pkg::PAD_EXT_UPPER] = 1'b1;
					else
					begin
						next_pads[boot_strap_pkg::PAD_EXT_LOWER] = 1'b1;
						next_ext_mux = 1'b1;
					end
				end
				boot_strap_pkg::DEV_NAND:
				begin
					next_cs_zero   = 1'b1; // [RQ8]
					next_wide      = cfg.byte_two[boot_strap_pkg::NAND_WIDE_BIT];
					next_over_pata = cfg.byte_two[boot_strap_pkg::NAND_ROUTE_BIT];
					next_pads[boot_strap_pkg::PAD_NAND_CTRL] = 1'b1;
					if (next_over_pata)
						next_pads[boot_strap_pkg::PAD_PATA_DATA] = 1'b1;
					else
						next_pads[boot_strap_pkg::PAD_EXT_LOWER] = 1'b1;
				end
				default:
					next_pads = boot_strap_pkg::PAD_NONE;
			endcase
		end
	end

	// Registers the steering outputs.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pads      <= boot_strap_pkg::PAD_NONE;
			ss_one    <= 1'b0;
			cs_zero   <= 1'b0;
			ext_mux   <= 1'b0;
			wide      <= 1'b0;
			over_pata <= 1'b0;
		end
		else
		begin
			pads      <= next_pads;
			ss_one    <= next_ss_one;
			cs_zero   <= next_cs_zero;
			ext_mux   <= next_ext_mux;
			wide      <= next_wide;
			over_pata <= next_over_pata;
		end
	end

	// Drives the results back through the carrier.
	assign cfg.pad_group_enable         = pads;
	assign cfg.slave_select_one_enable  = ss_one;
	assign cfg.chip_select_zero_enable  = cs_zero;
	assign cfg.external_bus_multiplexed = ext_mux;
	assign cfg.nand_wide                = wide;
	assign cfg.nand_over_pata           = over_pata;

	// Serial pads never appear without the single slave select.
	a_spi_ss_one: assert property (@(posedge clock) disable iff (!rst_b) // [RQ6]
		(|pads[boot_strap_pkg::PAD_SPI_TWO:boot_strap_pkg::PAD_LEGACY_SPI]) == ss_one)
		else $error("Slave select one does not follow the serial pad groups.");

	// Lower and upper external lanes are never allocated together.
	a_ext_lanes_one: assert property (@(posedge clock) disable iff (!rst_b) // [RQ7]
		!(pads[boot_strap_pkg::PAD_EXT_LOWER] && pads[boot_strap_pkg::PAD_EXT_UPPER])
		&& (ext_mux == (pads[boot_strap_pkg::PAD_EXT_LOWER] && pads[boot_strap_pkg::PAD_EXT_CTRL])))
		else $error("External bus lanes or multiplexing are inconsistent.");

	// Chip select zero only for the memory bus or NAND.
	a_chip_select_zero: assert property (@(posedge clock) disable iff (!rst_b) // [RQ8]
		cs_zero == (pads[boot_strap_pkg::PAD_EXT_CTRL] || pads[boot_strap_pkg::PAD_NAND_CTRL]))
		else $error("Chip select zero is not tied to its interface.");

	// Without boot activity no pad is claimed one cycle later.
	a_pads_idle: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
		!cfg.boot_active |=> (pads == boot_strap_pkg::PAD_NONE) && !ss_one && !cs_zero)
		else $error("Pads stay allocated outside boot.");

endmodule

`default_nettype wire

//--- hw/boot_strap_fuse_override.sv
// Purpose: Captures strap or fuse boot configuration and steers boot pads.
// Assumes: Straps and fuse outputs are steady and synchronous around reset release.
// Notes: Capture happens on the first clock edge after rst_b is released.
//
// How it works
// RQ1: Strap levels are sampled when reset ends, as candidate boot configuration.
// RQ2: Select low takes strap values; select high takes fuses and ignores straps.
// RQ3: An unblown select fuse reads low, so straps govern by default.
// RQ4: Straps fill byte one 7:0, byte two 7:2, byte three 7:1.
// RQ5: During boot only the chosen interface's pad groups are routed.
// RQ6: Serial boot drives slave select one only.
// RQ7: Memory bus boot uses lower lanes multiplexed or upper plain, chip select zero.
// RQ8: NAND boot is 8 or 16 bits over bus or ATA lanes, select zero.
// RQ9: Boot mode straps are captured without fuse path; all held until reset.
`default_nettype none

module boot_strap_fuse_override (
	input  wire logic                                 clock,
	input  wire logic                                 rst_b,
	input  wire logic [boot_strap_pkg::MODE_W-1:0]    boot_mode_strap,
	input  wire logic [boot_strap_pkg::CFG_W-1:0]     strap_byte_one,
	input  wire logic [boot_strap_pkg::CFG_W-1:boot_strap_pkg::BYTE_TWO_STRAP_LSB]
	                                                  strap_byte_two,
	input  wire logic [boot_strap_pkg::CFG_W-1:boot_strap_pkg::BYTE_THREE_STRAP_LSB]
	                                                  strap_byte_three,
	input  wire logic                                 fuse_source_select,
	input  wire logic [boot_strap_pkg::CFG_W-1:0]     fuse_byte_one,
	input  wire logic [boot_strap_pkg::CFG_W-1:0]     fuse_byte_two,
	input  wire logic [boot_strap_pkg::CFG_W-1:0]     fuse_byte_three,
	input  wire logic                                 boot_active,
	output logic      [boot_strap_pkg::MODE_W-1:0]    boot_mode,
	output logic      [boot_strap_pkg::CFG_W-1:0]     boot_config_byte_one,
	output logic      [boot_strap_pkg::CFG_W-1:0]     boot_config_byte_two,
	output logic      [boot_strap_pkg::CFG_W-1:0]     boot_config_byte_three,
	output logic                                      config_captured,
	output logic                                      fuses_in_use,
	output logic      [boot_strap_pkg::PAD_GROUPS-1:0] pad_group_enable,
	output logic                                      slave_select_one_enable,
	output logic                                      chip_select_zero_enable,
	output logic                                      external_bus_multiplexed,
	output logic                                      nand_wide,
	output logic                                      nand_over_pata
);

	boot_strap_pkg::load_state_t           state;
	boot_strap_pkg::load_state_t           next_state;
	logic [boot_strap_pkg::MODE_W-1:0]     mode;
	logic [boot_strap_pkg::MODE_W-1:0]     next_mode;
	logic [boot_strap_pkg::CFG_W-1:0]      cfg_one;
	logic [boot_strap_pkg::CFG_W-1:0]      next_cfg_one;
	logic [boot_strap_pkg::CFG_W-1:0]      cfg_two;
	logic [boot_strap_pkg::CFG_W-1:0]      next_cfg_two;
	logic [boot_strap_pkg::CFG_W-1:0]      cfg_three;
	logic [boot_strap_pkg::CFG_W-1:0]      next_cfg_three;
	logic                                  sel;
	logic                                  next_sel;
	logic [boot_strap_pkg::CFG_W-1:0]      strap_full_two;
	logic [boot_strap_pkg::CFG_W-1:0]      strap_full_three;

	boot_cfg_if link ();

	// Chooses the fuse byte when the select fuse is blown, else the strapped byte.
	function automatic logic [boot_strap_pkg::CFG_W-1:0] pick_byte(
		input logic [boot_strap_pkg::CFG_W-1:0] strap_val,
		input logic [boot_strap_pkg::CFG_W-1:0] fuse_val,
		input logic                             use_fuse
	);
		return use_fuse ? fuse_val : strap_val; // [RQ2]
	endfunction

	// Bits with no strap keep their fuse value even when straps override.
	assign strap_full_two = {strap_byte_two,
		fuse_byte_two[boot_strap_pkg::BYTE_TWO_STRAP_LSB-1:0]}; // [RQ4]
	assign strap_full_three = {strap_byte_three,
		fuse_byte_three[boot_strap_pkg::BYTE_THREE_STRAP_LSB-1:0]}; // [RQ4]

	// Captures once after reset release, then holds every value.
	always_comb
	begin
		next_state     = state;
		next_mode      = mode;
		next_cfg_one   = cfg_one;
		next_cfg_two   = cfg_two;
		next_cfg_three = cfg_three;
		next_sel       = sel;
		case (state)
			boot_strap_pkg::load_capture:
			begin
				next_mode      = boot_mode_strap; // [RQ9]
				next_sel       = fuse_source_select; // [RQ3]
				next_cfg_one   = pick_byte(strap_byte_one, fuse_byte_one,
					fuse_source_select); // [RQ1]
				next_cfg_two   = pick_byte(strap_full_two, fuse_byte_two,
					fuse_source_select); // [RQ2]
				next_cfg_three = pick_byte(strap_full_three, fuse_byte_three,
					fuse_source_select); // [RQ4]
				next_state     = boot_strap_pkg::load_hold;
			end
			boot_strap_pkg::load_hold:
				next_state = boot_strap_pkg::load_hold; // [RQ9]
			default:
				next_state = boot_strap_pkg::load_capture;
		endcase
	end

	// Registers the capture state; reset leaves the select at its unblown value.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state     <= boot_strap_pkg::load_capture;
			mode      <= boot_strap_pkg::MODE_RESET;
			cfg_one   <= boot_strap_pkg::CFG_RESET;
			cfg_two   <= boot_strap_pkg::CFG_RESET;
			cfg_three <= boot_strap_pkg::CFG_RESET;
			sel       <= boot_strap_pkg::SEL_RESET; // [RQ3]
		end
		else
		begin
			state     <= next_state;
			mode      <= next_mode;
			cfg_one   <= next_cfg_one;
			cfg_two   <= next_cfg_two;
			cfg_three <= next_cfg_three;
			sel       <= next_sel;
		end
	end

	// Hands the captured configuration to the pad steering logic.
	assign link.byte_one    = cfg_one;
	assign link.byte_two    = cfg_two;
	assign link.byte_three  = cfg_three;
	assign link.captured    = (state == boot_strap_pkg::load_hold);
	assign link.boot_active = boot_active;

	boot_pad_steer steer (
		.clock (clock),
		.rst_b (rst_b),
		.cfg   (link.steer)
	);

	// Top level outputs.
	assign boot_mode                = mode;
	assign boot_config_byte_one     = cfg_one;
	assign boot_config_byte_two     = cfg_two;
	assign boot_config_byte_three   = cfg_three;
	assign config_captured          = (state == boot_strap_pkg::load_hold);
	assign fuses_in_use             = sel;
	assign pad_group_enable         = link.pad_group_enable;
	assign slave_select_one_enable  = link.slave_select_one_enable;
	assign chip_select_zero_enable  = link.chip_select_zero_enable;
	assign external_bus_multiplexed = link.external_bus_multiplexed;
	assign nand_wide                = link.nand_wide;
	assign nand_over_pata           = link.nand_over_pata;

	// Strap capture when the select fuse is unblown.
	a_strap_capture: assert property (@(posedge clock) disable iff (!rst_b) // [RQ1]
		(state == boot_strap_pkg::load_capture && !fuse_source_select)
		|=> cfg_one == $past(strap_byte_one)
		&& cfg_two[boot_strap_pkg::CFG_W-1:boot_strap_pkg::BYTE_TWO_STRAP_LSB]
		== $past(strap_byte_two))
		else $error("Strapped bytes were not captured.");

	// Fuse bytes win when the select fuse is blown.
	a_fuse_capture: assert property (@(posedge clock) disable iff (!rst_b) // [RQ2]
		(state == boot_strap_pkg::load_capture && fuse_source_select)
		|=> cfg_one == $past(fuse_byte_one) && cfg_two == $past(fuse_byte_two)
		&& cfg_three == $past(fuse_byte_three) && sel)
		else $error("Fuse bytes were not used with the select fuse blown.");

	// Byte three strap bits and the unstrapped low bits.
	a_partial_bytes: assert property (@(posedge clock) disable iff (!rst_b) // [RQ4]
		(state == boot_strap_pkg::load_capture && !fuse_source_select)
		|=> cfg_three == {$past(strap_byte_three),
		$past(fuse_byte_three[boot_strap_pkg::BYTE_THREE_STRAP_LSB-1:0])}
		&& cfg_two[boot_strap_pkg::BYTE_TWO_STRAP_LSB-1:0]
		== $past(fuse_byte_two[boot_strap_pkg::BYTE_TWO_STRAP_LSB-1:0]))
		else $error("Partial strap bytes were assembled wrongly.");

	// Before capture the select reads as unblown.
	a_select_default: assert property (@(posedge clock) disable iff (!rst_b) // [RQ3]
		state == boot_strap_pkg::load_capture |-> !sel && !fuses_in_use)
		else $error("Select reads blown before capture.");

	// Boot mode comes from the straps in every case.
	a_mode_capture: assert property (@(posedge clock) disable iff (!rst_b) // [RQ9]
		state == boot_strap_pkg::load_capture |=> mode == $past(boot_mode_strap)
		&& config_captured)
		else $error("Boot mode strap was not captured.");

	// Captured values stay put until the next reset.
	a_values_hold: assert property (@(posedge clock) disable iff (!rst_b) // [RQ9]
		state == boot_strap_pkg::load_hold |=> $stable(mode) && $stable(cfg_one)
		&& $stable(cfg_two) && $stable(cfg_three) && $stable(sel)
		&& state == boot_strap_pkg::load_hold)
		else $error("Captured configuration changed after capture.");

	// At most one interface family owns pads at any time.
	a_one_interface: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
		$onehot0({slave_select_one_enable, chip_select_zero_enable}))
		else $error("More than one boot interface holds pads.");

	// Pads stay unclaimed until the configuration has been captured.
	a_pads_after_capture: assert property (@(posedge clock) disable iff (!rst_b) // [RQ5]
		!config_captured |=> pad_group_enable == boot_strap_pkg::PAD_NONE)
		else $error("Pads were claimed before the configuration was captured.");

	// Serial boot claims exactly one controller's pad group and nothing else.
	a_serial_alone: assert property (@(posedge clock) disable iff (!rst_b) // [RQ6]
		slave_select_one_enable |-> $onehot(pad_group_enable))
		else $error("Serial boot claims more than one pad group.");

	// NAND width and route flags appear only with the NAND interface.
	a_nand_flags: assert property (@(posedge clock) disable iff (!rst_b) // [RQ8]
		(nand_wide || nand_over_pata)
		|-> pad_group_enable[boot_strap_pkg::PAD_NAND_CTRL] && chip_select_zero_enable)
		else $error("NAND flags are set without the NAND interface.");

	// NAND data takes either the ATA lanes or the lower bus lanes, never both.
	a_nand_route: assert property (@(posedge clock) disable iff (!rst_b) // [RQ8]
		pad_group_enable[boot_strap_pkg::PAD_NAND_CTRL]
		|-> (pad_group_enable[boot_strap_pkg::PAD_PATA_DATA] == nand_over_pata)
		&& (pad_group_enable[boot_strap_pkg::PAD_EXT_LOWER] == !nand_over_pata))
		else $error("NAND data lanes do not match the chosen route.");

endmodule

`default_nettype wire

//--- testbench/strap_fuse_model.sv
// Purpose: Board strap resistors and on-chip fuse array facing the boot loader.
// Assumes: The bench sets the strap and fuse words before reset is released.
// Notes: Strap word is mode[22:21], byte one[20:13], byte two[12:7], byte three[6:0].
`default_nettype none

module strap_fuse_model (
	input  wire logic        blown_select,
	input  wire logic [22:0] strap_word,
	input  wire logic [23:0] fuse_word,
	output logic      [1:0]  mode_pins,
	output logic      [7:0]  strap_one,
	output logic      [7:2]  strap_two,
	output logic      [7:1]  strap_three,
	output logic             select_fuse,
	output logic      [7:0]  fuse_one,
	output logic      [7:0]  fuse_two,
	output logic      [7:0]  fuse_three
);
	timeunit 1ns;
	timeprecision 1ps;

	// Strap pins hold the resistor levels; only the strapped bits of each byte exist.
	always_comb
	begin
		mode_pins   = strap_word[22:21];
		strap_one   = strap_word[20:13];
		strap_two   = strap_word[12:7];
		strap_three = strap_word[6:0];
	end

	// Fuse array outputs; an unblown select fuse reads low.
	always_comb
	begin
		select_fuse = blown_select;
		fuse_one    = fuse_word[23:16];
		fuse_two    = fuse_word[15:8];
		fuse_three  = fuse_word[7:0];
	end
endmodule

`default_nettype wire

//--- testbench/boot_strap_fuse_override_tb.sv
// Purpose: Self-checking bench for the boot strap and fuse override loader.
// Assumes: Each case resets the block, so every case is a fresh capture.
// Notes: Random strap and fuse words, with device codes and options forced per case.
`default_nettype none

module boot_strap_fuse_override_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock        = 1'b0;
	logic        rst_b        = 1'b0;
	logic        boot_active  = 1'b0;
	logic        blown_select = 1'b0;
	logic [22:0] strap_word   = 23'h000000;
	logic [23:0] fuse_word    = 24'h000000;
	logic [31:0] seed         = 32'h9e181bed;
	int          bad_count    = 0;
	int          num_checks   = 0;
	wire logic [1:0] mode_pins;
	wire logic [7:0] strap_one;
	wire logic [7:2] strap_two;
	wire logic [7:1] strap_three;
	wire logic       select_fuse;
	wire logic [7:0] fuse_one;
	wire logic [7:0] fuse_two;
	wire logic [7:0] fuse_three;
	wire logic [1:0] boot_mode;
	wire logic [7:0] byte_one;
	wire logic [7:0] byte_two;
	wire logic [7:0] byte_three;
	wire logic       config_captured;
	wire logic       fuses_in_use;
	wire logic [7:0] pads;
	wire logic       ss1;
	wire logic       cs0;
	wire logic       muxed;
	wire logic       wide;
	wire logic       pata;
	wire logic [12:0] pad_word;
	logic [3:0]      dev_table [8] = '{4'h0, 4'h1, 4'h3, 4'h3, 4'h3, 4'h3, 4'h7, 4'h0};

	assign pad_word = {pads, ss1, cs0, muxed, wide, pata};

	// Clock at 25 MHz.
	always #20 clock = ~clock;

	strap_fuse_model model_u (.blown_select(blown_select), .strap_word(strap_word),
		.fuse_word(fuse_word), .mode_pins(mode_pins), .strap_one(strap_one),
		.strap_two(strap_two), .strap_three(strap_three), .select_fuse(select_fuse),
		.fuse_one(fuse_one), .fuse_two(fuse_two), .fuse_three(fuse_three));

	boot_strap_fuse_override dut_u (.clock(clock), .rst_b(rst_b),
		.boot_mode_strap(mode_pins), .strap_byte_one(strap_one),
		.strap_byte_two(strap_two), .strap_byte_three(strap_three),
		.fuse_source_select(select_fuse), .fuse_byte_one(fuse_one),
		.fuse_byte_two(fuse_two), .fuse_byte_three(fuse_three),
		.boot_active(boot_active), .boot_mode(boot_mode),
		.boot_config_byte_one(byte_one), .boot_config_byte_two(byte_two),
		.boot_config_byte_three(byte_three), .config_captured(config_captured),
		.fuses_in_use(fuses_in_use), .pad_group_enable(pads),
		.slave_select_one_enable(ss1), .chip_select_zero_enable(cs0),
		.external_bus_multiplexed(muxed), .nand_wide(wide), .nand_over_pata(pata));

	// Xorshift step for repeatable random words.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	// Expected bytes one, two, three; straps fill only their bits, fuses the rest.
	function automatic logic [23:0] exp_cfg(input logic sel, input logic [22:0] st,
		input logic [23:0] fu);
		if (sel)
			return fu;
		return {st[20:13], st[12:7], fu[9:8], st[6:0], fu[0]};
	endfunction

	// Expected pads, then slave select, chip select, muxed, wide, over-ATA flags.
	function automatic logic [12:0] exp_pads(input logic [23:0] c);
		logic [7:0] p;
		logic [4:0] f;
		p = 8'h00;
		f = 5'h00;
		case (c[23:20])
			boot_strap_pkg::DEV_EXT_BUS:
			begin
				p[3] = 1'b1;
				p[c[11] ? 5 : 4] = 1'b1;
				f = {2'b01, ~c[11], 2'b00};
			end
			boot_strap_pkg::DEV_NAND:
			begin
				p[6] = 1'b1;
				p[c[13] ? 7 : 4] = 1'b1;
				f = {3'b010, c[12], c[13]};
			end
			boot_strap_pkg::DEV_SPI:
			begin
				if (c[5:4] != 2'h3)
				begin
					p[c[5:4]] = 1'b1;
					f = 5'h10;
				end
			end
			default: ;
		endcase
		return {p, f};
	endfunction

	// Compare tasks, one per kind of result.
	task automatic check_cfg(input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic check_pads(input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic check_flag(input logic e, input logic g);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("BAD t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One reset, capture, boot and release; later pin changes must not leak in.
	task automatic run_case(input int i);
		logic [23:0] c;
		logic [22:0] st;
		logic        sel;
		@(negedge clock);
		rst_b = 1'b0;
		seed = xs(seed);
		strap_word = seed[22:0];
		seed = xs(seed);
		fuse_word = seed[23:0];
		strap_word[20:17] = dev_table[i[2:0]];
		fuse_word[23:20] = dev_table[i[2:0]];
		strap_word[10:8] = {i[4], i[3], i[3]};
		fuse_word[13:11] = {i[4], i[3], i[3]};
		strap_word[4:3] = i[1:0];
		fuse_word[5:4] = i[1:0];
		blown_select = i[4] ^ i[3];
		repeat (2) @(negedge clock);
		check_flag(1'b0, config_captured);
		check_flag(1'b0, fuses_in_use);
		rst_b = 1'b1;
		@(negedge clock);
		sel = blown_select;
		st = strap_word;
		c = exp_cfg(sel, st, fuse_word);
		check_flag(1'b1, config_captured);
		check_flag(sel, fuses_in_use);
		check_cfg(c[23:16], byte_one);
		check_cfg(c[15:8], byte_two);
		check_cfg(c[7:0], byte_three);
		check_cfg({6'h00, st[22:21]}, {6'h00, boot_mode});
		strap_word = ~strap_word;
		fuse_word = ~fuse_word;
		blown_select = ~blown_select;
		boot_active = 1'b1;
		@(negedge clock);
		check_pads(exp_pads(c), pad_word);
		check_cfg(c[23:16], byte_one);
		check_cfg(c[7:0], byte_three);
		check_cfg({6'h00, st[22:21]}, {6'h00, boot_mode});
		check_flag(sel, fuses_in_use);
		boot_active = 1'b0;
		@(negedge clock);
		check_pads(13'h0000, pad_word);
		$display("case %0d done", i);
	endtask

	// Main sequence: long reset at start, then the cases.
	initial
	begin
		repeat (16) @(negedge clock);
		for (int i = 0; i < 32; i++)
			run_case(i);
		test_done();
	end

	// Watchdog well beyond the expected run of about 208 cycles.
	initial
	begin
		#200000;
		bad_count++;
		test_done();
	end
endmodule

`default_nettype wire
